// [hw/tdr_pkg.sv]
// Package for the topology detection register block
package tdr_pkg;
  localparam int          TDR_ADDR_W       = 12;
  localparam int          TDR_DATA_W       = 32;
  localparam int          TDR_NUM_OUT      = 8;
  localparam int          TDR_NUM_IN       = 8;
  localparam int          TDR_SEL_W        = 5;
  // Register byte offsets
  localparam logic [11:0] TDR_OFF_MODE     = 12'hf00;
  localparam logic [11:0] TDR_OFF_OUT      = 12'hf04;
  localparam logic [11:0] TDR_OFF_IN       = 12'hf08;
  localparam logic [11:0] TDR_OFF_CONN     = 12'hf0c;
  localparam logic [11:0] TDR_OFF_COUNT    = 12'hf10;
  localparam logic [11:0] TDR_OFF_SEL      = 12'hf14;
  // Field positions and reset values
  localparam int          TDR_MODE_EN_BIT  = 0;
  localparam logic        TDR_MODE_EN_RST  = 1'b0;
  localparam logic [7:0]  TDR_OUT_RST      = 8'h00;
  localparam logic [4:0]  TDR_SEL_RST      = 5'h00;
  localparam logic [1:0]  TDR_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  TDR_RESP_SLVERR  = 2'b10;
  // Decoded register select
  typedef enum logic [2:0] {
    TDR_R_CTRL, TDR_R_OUT, TDR_R_IN, TDR_R_CONN, TDR_R_COUNT, TDR_R_SEL, TDR_R_NONE
  } tdr_reg_t;
endpackage

// [hw/tdr_regs_if.sv]
// Register access strobes between bus slave and register file
`timescale 1ns/1ps
interface tdr_regs_if;
  import tdr_pkg::*;
  logic                  wr_en;
  tdr_reg_t              wr_reg;
  logic [TDR_DATA_W-1:0] wr_data;
  logic [3:0]            wr_strb;
  tdr_reg_t              rd_reg;
  logic [TDR_DATA_W-1:0] rd_data;
  modport slave (output wr_en, wr_reg, wr_data, wr_strb, rd_reg, input rd_data);
  modport regs  (input wr_en, wr_reg, wr_data, wr_strb, rd_reg, output rd_data);
endinterface

// [hw/tdr_axil_slave.sv]
// AXI4-Lite slave front end for the register file
`timescale 1ns/1ps
module tdr_axil_slave
  import tdr_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [TDR_ADDR_W-1:0] s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [TDR_DATA_W-1:0] s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [TDR_ADDR_W-1:0] s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [TDR_DATA_W-1:0]      s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  tdr_regs_if.slave                  rif
);
  import tdr_pkg::*;

  function automatic tdr_reg_t dec(input logic [TDR_ADDR_W-1:0] a);
    case ({a[TDR_ADDR_W-1:2], 2'b00})
      TDR_OFF_MODE:   dec = TDR_R_CTRL;
      TDR_OFF_OUT:    dec = TDR_R_OUT;
      TDR_OFF_IN:     dec = TDR_R_IN;
      TDR_OFF_CONN:   dec = TDR_R_CONN;
      TDR_OFF_COUNT:  dec = TDR_R_COUNT;
      TDR_OFF_SEL:    dec = TDR_R_SEL;
      default:        dec = TDR_R_NONE;
    endcase
  endfunction

  logic                  aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [TDR_ADDR_W-1:0] awa_r, awa_nxt;
  logic [TDR_DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]            ws_r, ws_nxt;
  logic [1:0]            br_r, br_nxt, rr_r, rr_nxt;
  logic                  do_wr;

  // Address and data latched separately, either order
  assign s_awready = !aw_r && !bv_r;
  assign s_wready  = !w_r && !bv_r;
  assign s_arready = !rv_r;
  assign do_wr     = aw_r && w_r && !bv_r;
  assign rif.wr_en   = do_wr;
  assign rif.wr_reg  = dec(awa_r);
  assign rif.wr_data = wd_r;
  assign rif.wr_strb = ws_r;
  assign rif.rd_reg  = dec(s_araddr);

  always_comb begin
    aw_nxt = aw_r; awa_nxt = awa_r; w_nxt = w_r; wd_nxt = wd_r; ws_nxt = ws_r;
    bv_nxt = bv_r; br_nxt = br_r; rv_nxt = rv_r; rd_nxt = rd_r; rr_nxt = rr_r;
    if (s_awvalid && s_awready) begin
      aw_nxt  = 1'b1;
      awa_nxt = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_nxt  = 1'b1;
      wd_nxt = s_wdata;
      ws_nxt = s_wstrb;
    end
    if (do_wr) begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = (dec(awa_r) == TDR_R_NONE) ? TDR_RESP_SLVERR : TDR_RESP_OKAY;
    end else if (bv_r && s_bready) begin
      bv_nxt = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      rv_nxt = 1'b1;
      rd_nxt = rif.rd_data;
      rr_nxt = (dec(s_araddr) == TDR_R_NONE) ? TDR_RESP_SLVERR : TDR_RESP_OKAY;
    end else if (rv_r && s_rready) begin
      rv_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_r <= 1'b0; awa_r <= '0; w_r <= 1'b0; wd_r <= '0; ws_r <= 4'h0;
      bv_r <= 1'b0; br_r <= 2'b00; rv_r <= 1'b0; rd_r <= '0; rr_r <= 2'b00;
    end else begin
      aw_r <= aw_nxt; awa_r <= awa_nxt; w_r <= w_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
      bv_r <= bv_nxt; br_r <= br_nxt; rv_r <= rv_nxt; rd_r <= rd_nxt; rr_r <= rr_nxt;
    end
  end

  assign s_bvalid = bv_r;
  assign s_bresp  = br_r;
  assign s_rvalid = rv_r;
  assign s_rdata  = rd_r;
  assign s_rresp  = rr_r;
endmodule // tdr_axil_slave

// [hw/tdr_pin_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module tdr_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic [W-1:0]      level_out
);
  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

  // First stage feeds only the second; level moves when stages two and three agree
  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) lvl_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_r <= '0; s2_r <= '0; s3_r <= '0; lvl_r <= '0;
    end else begin
      s1_r <= pin_in; s2_r <= s1_r; s3_r <= s2_r; lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule // tdr_pin_sync

// [hw/tdr_top.sv]
// Topology detection registers with detection mode and variant select
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module tdr_top
  import tdr_pkg::*;
#(
  parameter int NUM_OUT = TDR_NUM_OUT,
  parameter int NUM_IN  = TDR_NUM_IN
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [TDR_ADDR_W-1:0] s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [TDR_DATA_W-1:0] s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [TDR_ADDR_W-1:0] s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [TDR_DATA_W-1:0]      s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  input  wire logic [NUM_OUT-1:0]    func_out,
  output logic [NUM_OUT-1:0]         det_out,
  input  wire logic [NUM_IN-1:0]     det_in,
  output logic [NUM_IN-1:0]          func_in,
  input  wire logic [NUM_IN-1:0]     iface_present,
  input  wire logic [TDR_SEL_W-1:0]  variant_count,
  output logic [TDR_SEL_W-1:0]       variant_sel,
  output logic                       detect_mode
);
  import tdr_pkg::*;

  tdr_regs_if rif ();

  logic                 mode_en_r, mode_en_nxt;
  logic [NUM_OUT-1:0]   drv_r, drv_nxt;
  logic [NUM_OUT-1:0]   out_r, out_nxt;
  logic [NUM_IN-1:0]    fin_r, fin_nxt;
  logic [TDR_SEL_W-1:0] sel_r, sel_nxt;
  logic [NUM_IN-1:0]    in_lvl;
  logic [NUM_IN-1:0]    pres_lvl;
  logic [TDR_SEL_W-1:0] cnt_r;

  tdr_axil_slave u_slave (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .rif       (rif)
  );

  // Pins from neighbours are asynchronous to this clock
  tdr_pin_sync #(.W(NUM_IN)) u_in_sync (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .pin_in    (det_in),
    .level_out (in_lvl)
  );

  tdr_pin_sync #(.W(NUM_IN)) u_pres_sync (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .pin_in    (iface_present),
    .level_out (pres_lvl)
  );

  // Register writes; only byte lane 0 carries the narrow fields
  always_comb begin
    mode_en_nxt = mode_en_r;
    drv_nxt = drv_r;
    sel_nxt = sel_r;
    if (rif.wr_en && rif.wr_strb[0]) begin
      case (rif.wr_reg)
        TDR_R_CTRL: mode_en_nxt = rif.wr_data[TDR_MODE_EN_BIT];
        TDR_R_OUT:  drv_nxt = rif.wr_data[NUM_OUT-1:0];
        TDR_R_SEL: begin
          // Out-of-range selections are ignored so the count stays meaningful
          if (rif.wr_data[TDR_SEL_W-1:0] < cnt_r) sel_nxt = rif.wr_data[TDR_SEL_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Output path: detection value in detection mode, functional otherwise
  always_comb begin
    out_nxt = mode_en_r ? drv_r : func_out;
    // Functional side sees zeros while isolated, so probing stays invisible to it
    // Synchronised level only; the raw pin is asynchronous to this clock
    fin_nxt = mode_en_r ? '0 : in_lvl;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_en_r <= TDR_MODE_EN_RST;
      drv_r <= TDR_OUT_RST[NUM_OUT-1:0];
      sel_r <= TDR_SEL_RST;
      out_r <= '0;
      fin_r <= '0;
      cnt_r <= '0;
    end else begin
      mode_en_r <= mode_en_nxt;
      drv_r <= drv_nxt;
      sel_r <= sel_nxt;
      out_r <= out_nxt;
      fin_r <= fin_nxt;
      cnt_r <= variant_count;
    end
  end

  // Reads; unused bits read as zero
  always_comb begin
    rif.rd_data = '0;
    case (rif.rd_reg)
      TDR_R_CTRL:  rif.rd_data[TDR_MODE_EN_BIT] = mode_en_r;
      TDR_R_OUT:   rif.rd_data[NUM_OUT-1:0] = drv_r;
      TDR_R_IN:    rif.rd_data[NUM_IN-1:0]  = in_lvl;
      TDR_R_CONN:  rif.rd_data[NUM_IN-1:0]  = pres_lvl;
      TDR_R_COUNT: rif.rd_data[TDR_SEL_W-1:0] = cnt_r;
      TDR_R_SEL:   rif.rd_data[TDR_SEL_W-1:0] = sel_r;
      default:     rif.rd_data = '0;
    endcase
  end

  assign det_out     = out_r;
  assign func_in     = fin_r;
  assign variant_sel = sel_r;
  assign detect_mode = mode_en_r;
endmodule // tdr_top

// [testbench/tdr_top_asserts.sv]
// Port-level assertion checker for the topology detection block
`timescale 1ns/1ps
module tdr_top_asserts
  import tdr_pkg::*;
#(
  parameter int NUM_OUT = TDR_NUM_OUT,
  parameter int NUM_IN  = TDR_NUM_IN
) (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire logic                  s_awvalid,
  input wire logic                  s_awready,
  input wire logic                  s_wvalid,
  input wire logic                  s_wready,
  input wire logic                  s_bvalid,
  input wire logic                  s_bready,
  input wire logic                  s_arvalid,
  input wire logic                  s_arready,
  input wire logic                  s_rvalid,
  input wire logic                  s_rready,
  input wire logic [TDR_DATA_W-1:0] s_rdata,
  input wire logic [NUM_OUT-1:0]    func_out,
  input wire logic [NUM_OUT-1:0]    det_out,
  input wire logic [NUM_IN-1:0]     det_in,
  input wire logic [NUM_IN-1:0]     func_in,
  input wire logic [TDR_SEL_W-1:0]  variant_count,
  input wire logic [TDR_SEL_W-1:0]  variant_sel,
  input wire logic                  detect_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready
    |-> ##2 s_bvalid) else $error("write response late");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read response late");
  a_b_holds: assert property (s_bvalid && !s_bready |=> s_bvalid) else $error("bvalid dropped");
  a_r_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  a_busy_refuse: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while answering");
  a_rd_refuse: assert property (s_rvalid |-> !s_arready) else $error("read taken while answering");
  a_func_follow: assert property (!detect_mode |=> det_out == $past(func_out))
    else $error("output not following source");
  a_mode_isolate: assert property (detect_mode |=> func_in == '0)
    else $error("input not isolated");
  // Pin passes the synchroniser first, so only a settled input is compared
  a_in_copy: assert property ((!detect_mode && $stable(det_in)) [*6]
    |=> func_in == $past(det_in))
    else $error("functional input wrong");
  a_sel_range: assert property (variant_sel != '0 |-> variant_sel < variant_count)
    else $error("selection out of range");
  cover property (detect_mode && det_out != '0);
  cover property (s_bvalid && !s_bready);
  cover property (s_rvalid && !s_rready);
endmodule // tdr_top_asserts

bind tdr_top tdr_top_asserts #(.NUM_OUT(NUM_OUT), .NUM_IN(NUM_IN)) i_tdr_top_asserts (
  .clk_sys, .sys_rst, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready,
  .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .func_out, .det_out, .det_in,
  .func_in, .variant_count, .variant_sel, .detect_mode);

// [testbench/tdr_neighbour.sv]
// Neighbour component model on the probed interfaces
`timescale 1ns/1ps
module tdr_neighbour #(
  parameter logic [7:0] LINKED = 8'h5b
) (
  input  wire logic [7:0] det_out,
  output logic [7:0]      det_in,
  output logic [7:0]      iface_present
);
  // Unlinked lines rest on their pull-down, same as an absent one
  assign det_in        = det_out & LINKED;
  assign iface_present = LINKED;
endmodule // tdr_neighbour

// [testbench/tdr_top_tb.sv]
// Self-checking testbench for the topology detection block
`timescale 1ns/1ps
module tdr_top_tb;
  import tdr_pkg::*;
  localparam logic [4:0] NALT   = 5'h06;
  localparam logic [7:0] LINKED = 8'h5b;
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  logic [11:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic [3:0]  s_wstrb = 4'hf;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, detect_mode;
  logic [1:0]  s_bresp, s_rresp;
  logic [7:0]  func_out = '0, det_out, det_in, func_in, iface_present;
  logic [4:0]  variant_count = NALT, variant_sel;
  int bad_count = 0;
  int total_checks = 0;

  tdr_top i_tdr_top (.clk_sys, .sys_rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .func_out, .det_out, .det_in, .func_in,
    .iface_present, .variant_count, .variant_sel, .detect_mode);
  tdr_neighbour #(.LINKED(LINKED)) i_tdr_neighbour (.det_out, .det_in, .iface_present);

  always #50 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Answer ready stands from the request on, so the answer is taken at its first edge
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 40);
    s_bready <= 1'b0;
    if (n >= 40) bad_count++;
    chk(32'(s_bresp), 32'(er), "write response");
  endtask

  task automatic bus_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input string what);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 40);
    s_rready <= 1'b0;
    if (n >= 40) bad_count++;
    chk(s_rdata, ed, what);
    chk(32'(s_rresp), 32'(er), what);
  endtask

  task automatic t_reset_view;
    bus_rd(TDR_OFF_MODE, 32'h0, TDR_RESP_OKAY, "control at reset");
    bus_rd(TDR_OFF_COUNT, 32'(NALT), TDR_RESP_OKAY, "count");
    bus_rd(TDR_OFF_CONN, 32'(LINKED), TDR_RESP_OKAY, "connected flags");
    bus_rd(12'hf18, 32'h0, TDR_RESP_SLVERR, "unmapped read");
    bus_wr(12'hf18, 32'hffff_ffff, TDR_RESP_SLVERR);
  endtask

  task automatic t_functional;
    bus_wr(TDR_OFF_OUT, 32'h0000_00ff, TDR_RESP_OKAY);
    func_out <= 8'h3c;
    repeat (2) @(posedge clk_sys);
    chk(32'(det_out), 32'h3c, "functional drive");
    repeat (8) @(posedge clk_sys);
    chk(32'(func_in), 32'(8'h3c & LINKED), "functional input");
    bus_rd(TDR_OFF_IN, 32'(8'h3c & LINKED), TDR_RESP_OKAY, "input level");
  endtask

  task automatic t_detect;
    bus_wr(TDR_OFF_MODE, 32'h1, TDR_RESP_OKAY);
    bus_rd(TDR_OFF_MODE, 32'h1, TDR_RESP_OKAY, "control readback");
    chk(32'(detect_mode), 32'h1, "detect mode");
    chk(32'(det_out), 32'hff, "drive register");
    bus_wr(TDR_OFF_OUT, 32'h0000_00f7, TDR_RESP_OKAY);
    func_out <= 8'h00;
    repeat (2) @(posedge clk_sys);
    chk(32'(det_out), 32'hf7, "single bit drive");
    repeat (8) @(posedge clk_sys);
    chk(32'(func_in), 32'h0, "isolated input");
    bus_rd(TDR_OFF_IN, 32'(8'hf7 & LINKED), TDR_RESP_OKAY, "looped level");
  endtask

  task automatic t_variant;
    bus_wr(TDR_OFF_SEL, 32'(NALT - 5'h1), TDR_RESP_OKAY);
    bus_rd(TDR_OFF_SEL, 32'(NALT - 5'h1), TDR_RESP_OKAY, "last selection");
    bus_wr(TDR_OFF_SEL, 32'(NALT), TDR_RESP_OKAY);
    chk(32'(variant_sel), 32'(NALT - 5'h1), "selection beyond count");
    bus_rd(TDR_OFF_COUNT, 32'(NALT), TDR_RESP_OKAY, "count after switch");
    bus_rd(TDR_OFF_IN, 32'(8'hf7 & LINKED), TDR_RESP_OKAY, "detect after switch");
  endtask

  task automatic t_leave;
    bus_wr(TDR_OFF_MODE, 32'h0, TDR_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk(32'(det_out), 32'h00, "back to functional");
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus_rd(TDR_OFF_SEL, 32'h0, TDR_RESP_OKAY, "selection after reset");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs about a hundred cycles
  initial begin
    #(3000 * 100);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_view();
    t_functional();
    t_detect();
    t_variant();
    t_leave();
    print_verdict();
  end
endmodule // tdr_top_tb
